// ---- rtl/actag_codec_link.sv ----
// codec end of the serial audio link: slot tags, sample pacing, request display and dac update
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`include "actag_regs.svh"

// Functional notes
// - At 8 kHz one adc sample is delivered and one dac sample requested every sixth frame.
// - At 16 kHz a sample moves every third frame and at 12 kHz every fourth frame, evenly spaced.
// - An adc slot without a valid sample in the frame carries an all-zero word.
// - Adc valid flags and dac requests come from independent generators so their frames need not line up at fractional rates.
// - At fractional rates two back-to-back adc valid frames may come with zero or one dac request.
// - A requested dac sample that does not arrive is either repeated or replaced by zero as a control bit selects.
// - Request bits are active low in the status address slot and active high in the status data slot.
// - Request bits appear in status slots 1 and 2 only while the request display enable bit is set.
module actag_codec_link #(
	parameter int RATE_W = 16
) (
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic BIT_CLK_IN,
	input wire logic SYNC_IN,
	input wire logic SDATA_OUT_IN,
	output logic SDATA_IN_OUT,
	output actag_pkg::actag_sample_t DAC_LEFT_OUT,
	output actag_pkg::actag_sample_t DAC_RIGHT_OUT
);
	import actag_pkg::*;

	if (RATE_W < 16 || RATE_W > 31) begin : g_bad_rate_w
		$error("RATE_W must lie between 16 and 31");
	end

	// pin synchronisers: bit clock, frame sync, serial data from the host
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic bclk_prev_q;
	logic sync_prev_q;
	logic bclk_rise;
	logic bclk_fall;
	logic frame_start;

	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
			bclk_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= {SDATA_OUT_IN, SYNC_IN, BIT_CLK_IN};
			pin_s2_q <= pin_s1_q;
			bclk_prev_q <= pin_s2_q[0];
		end
	end

	assign bclk_rise = pin_s2_q[0] & ~bclk_prev_q;
	assign bclk_fall = ~pin_s2_q[0] & bclk_prev_q;
	assign frame_start = bclk_rise & pin_s2_q[1] & ~sync_prev_q;

	// bus slave state and registers
	actag_ctrl_t ctrl_q;
	logic [RATE_W-1:0] adc_rate_q;
	logic [RATE_W-1:0] dac_rate_q;
	actag_sample_t adc_smp_q [2];
	actag_sample_t dac_q [2];
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic hready_q;
	logic hresp_q;
	logic addr_phase;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	// frame state
	actag_link_state_t lnk_q;
	logic [3:0] slot_q;
	logic [4:0] sbit_q;
	logic [19:0] tx_sr_q;
	logic sdi_q;
	logic [19:0] rx_sr_q;
	actag_rx_frame_t rx_q;
	logic adc_v_q;
	logic req_cur_q;
	logic req_wait_q;
	actag_sample_t adc_frame_q [2];
	logic [15:0] frame_cnt_q;
	logic [7:0] starve_cnt_q;
	logic adc_tick;
	logic dac_tick;
	logic gen_step;
	logic [1:0] starve;

	// ahb-lite slave: writes take no wait state, reads take one
	assign addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_phase & HWRITE_IN;
			rd_pend_q <= addr_phase & ~HWRITE_IN;
			hresp_q <= 1'b0;
			if (addr_phase) begin
				addr_q <= HADDR_IN[7:0];
			end
			// read data taken a cycle late so a write just before is seen
			if (rd_pend_q) begin
				hrdata_q <= rd_mux;
			end
			hready_q <= ~(addr_phase & ~HWRITE_IN);
		end
	end

	assign status_word = {frame_cnt_q, starve_cnt_q, 4'h0, req_wait_q, req_cur_q, adc_v_q, lnk_q == LNK_FRAME};
	assign rd_mux = (addr_q == `ACTAG_CTRL_OFS) ? {29'h0, ctrl_q} :
		(addr_q == `ACTAG_ADC_RATE_OFS) ? 32'(adc_rate_q) :
		(addr_q == `ACTAG_DAC_RATE_OFS) ? 32'(dac_rate_q) :
		(addr_q == `ACTAG_ADC_LEFT_OFS) ? {16'h0, adc_smp_q[0]} :
		(addr_q == `ACTAG_ADC_RIGHT_OFS) ? {16'h0, adc_smp_q[1]} :
		(addr_q == `ACTAG_DAC_LEFT_OFS) ? {16'h0, dac_q[0]} :
		(addr_q == `ACTAG_DAC_RIGHT_OFS) ? {16'h0, dac_q[1]} :
		(addr_q == `ACTAG_STATUS_OFS) ? status_word : 32'h0000_0000;

	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ctrl_q <= actag_ctrl_t'(`ACTAG_CTRL_RST);
			adc_rate_q <= RATE_W'(`ACTAG_RATE_RST);
			dac_rate_q <= RATE_W'(`ACTAG_RATE_RST);
			adc_smp_q[0] <= 16'h0000;
			adc_smp_q[1] <= 16'h0000;
		end else if (wr_pend_q) begin
			if (addr_q == `ACTAG_CTRL_OFS) ctrl_q <= actag_ctrl_t'(HWDATA_IN[2:0]);
			if (addr_q == `ACTAG_ADC_RATE_OFS) adc_rate_q <= HWDATA_IN[RATE_W-1:0];
			if (addr_q == `ACTAG_DAC_RATE_OFS) dac_rate_q <= HWDATA_IN[RATE_W-1:0];
			if (addr_q == `ACTAG_ADC_LEFT_OFS) adc_smp_q[0] <= HWDATA_IN[15:0];
			if (addr_q == `ACTAG_ADC_RIGHT_OFS) adc_smp_q[1] <= HWDATA_IN[15:0];
		end
	end

	// independent pacing of capture and playback
	assign gen_step = frame_start & ctrl_q.run;

	actag_rate_gen #(.RATE_W(RATE_W), .BASE(`ACTAG_BASE_RATE)) u_adc_gen (
		.clk_in(CORE_CLK_IN),
		.nrst_in(NRST_IN),
		.step_in(gen_step),
		.rate_in(adc_rate_q),
		.tick_out(adc_tick)
	);

	actag_rate_gen #(.RATE_W(RATE_W), .BASE(`ACTAG_BASE_RATE)) u_dac_gen (
		.clk_in(CORE_CLK_IN),
		.nrst_in(NRST_IN),
		.step_in(gen_step),
		.rate_in(dac_rate_q),
		.tick_out(dac_tick)
	);

	// outgoing slot words
	logic [15:0] tag_word;
	logic [15:0] stat_addr_word;
	logic [15:0] stat_data_word;
	logic [3:0] slot_nxt;
	logic [15:0] slot_word;
	logic slot_end;

	assign tag_word = 16'h0000
		| (16'(ctrl_q.run) << `ACTAG_TAG_READY_BIT)
		| (16'(ctrl_q.req_disp_en) << `ACTAG_TAG_SLOT1_BIT)
		| (16'(ctrl_q.req_disp_en) << `ACTAG_TAG_SLOT2_BIT)
		| (16'(adc_tick & ctrl_q.run) << `ACTAG_TAG_LEFT_BIT)
		| (16'(adc_tick & ctrl_q.run) << `ACTAG_TAG_RIGHT_BIT);
	// low means requested in the address slot, high in the data slot
	assign stat_addr_word = `ACTAG_STAT_ADDR_BASE
		| ({15'h0000, ~req_cur_q} << `ACTAG_STAT_ADDR_LREQ_BIT)
		| ({15'h0000, ~req_cur_q} << `ACTAG_STAT_ADDR_RREQ_BIT);
	assign stat_data_word = `ACTAG_STAT_DATA_BASE
		| (16'(req_cur_q) << `ACTAG_STAT_DATA_LREQ_BIT)
		| (16'(req_cur_q) << `ACTAG_STAT_DATA_RREQ_BIT);
	assign slot_nxt = slot_q + 4'd1;
	assign slot_end = (slot_q == 4'd0) ? (sbit_q == `ACTAG_TAG_LAST_BIT) : (sbit_q == `ACTAG_SLOT_LAST_BIT);
	// status slots stay empty unless display is enabled, adc slots zero without a sample
	assign slot_word = (slot_nxt == 4'd1) ? (ctrl_q.req_disp_en ? stat_addr_word : 16'h0000) :
		(slot_nxt == 4'd2) ? (ctrl_q.req_disp_en ? stat_data_word : 16'h0000) :
		(slot_nxt == 4'd3) ? (adc_v_q ? adc_frame_q[0] : 16'h0000) :
		(slot_nxt == 4'd4) ? (adc_v_q ? adc_frame_q[1] : 16'h0000) : 16'h0000;

	// transmit on bit clock rise, receive on fall
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			lnk_q <= LNK_IDLE;
			sync_prev_q <= 1'b0;
			slot_q <= 4'd0;
			sbit_q <= 5'd0;
			tx_sr_q <= 20'h00000;
			sdi_q <= 1'b0;
			rx_sr_q <= 20'h00000;
			rx_q <= '0;
		end else begin
			if (bclk_rise) begin
				sync_prev_q <= pin_s2_q[1];
			end
			if (frame_start) begin
				lnk_q <= LNK_FRAME;
				slot_q <= 4'd0;
				sbit_q <= 5'd0;
				sdi_q <= tag_word[15];
				tx_sr_q <= {tag_word[14:0], 5'h00};
			end else if (bclk_rise && lnk_q == LNK_FRAME) begin
				if (!slot_end) begin
					sbit_q <= sbit_q + 5'd1;
					sdi_q <= tx_sr_q[19];
					tx_sr_q <= {tx_sr_q[18:0], 1'b0};
				end else if (slot_q == `ACTAG_LAST_SLOT) begin
					lnk_q <= LNK_IDLE;
					sdi_q <= 1'b0;
				end else begin
					slot_q <= slot_nxt;
					sbit_q <= 5'd0;
					sdi_q <= slot_word[15];
					tx_sr_q <= {slot_word[14:0], 5'h00};
				end
			end
			if (bclk_fall && lnk_q == LNK_FRAME) begin
				rx_sr_q <= {rx_sr_q[18:0], pin_s2_q[2]};
				if (slot_end && slot_q == 4'd0) rx_q.tag <= {rx_sr_q[14:0], pin_s2_q[2]};
				if (slot_end && slot_q == 4'd3) rx_q.left <= rx_sr_q[18:3];
				if (slot_end && slot_q == 4'd4) rx_q.right <= rx_sr_q[18:3];
			end
		end
	end

	// frame bookkeeping at each frame start
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			adc_v_q <= 1'b0;
			req_cur_q <= 1'b0;
			req_wait_q <= 1'b0;
			adc_frame_q[0] <= 16'h0000;
			adc_frame_q[1] <= 16'h0000;
			frame_cnt_q <= 16'h0000;
			starve_cnt_q <= 8'h00;
		end else if (frame_start) begin
			adc_v_q <= adc_tick & ctrl_q.run;
			req_cur_q <= dac_tick & ctrl_q.run;
			req_wait_q <= req_cur_q;
			adc_frame_q[0] <= adc_smp_q[0];
			adc_frame_q[1] <= adc_smp_q[1];
			frame_cnt_q <= frame_cnt_q + 16'h0001;
			if (|starve) starve_cnt_q <= starve_cnt_q + 8'h01;
		end
	end

	// a request issued last frame is answered in the frame just ended
	for (genvar ch = 0; ch < 2; ch++) begin : g_dac
		localparam int TAG_BIT = (ch == 0) ? `ACTAG_TAG_LEFT_BIT : `ACTAG_TAG_RIGHT_BIT;
		logic supplied;
		assign supplied = rx_q.tag[`ACTAG_TAG_READY_BIT] & rx_q.tag[TAG_BIT];
		assign starve[ch] = req_wait_q & ~supplied;
		always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
			if (!NRST_IN) begin
				dac_q[ch] <= 16'h0000;
			end else if (frame_start && req_wait_q) begin
				if (supplied) begin
					dac_q[ch] <= (ch == 0) ? rx_q.left : rx_q.right;
				end else if (ctrl_q.starve_zero) begin
					dac_q[ch] <= 16'h0000;
				end
			end
		end
	end

	assign HRDATA_OUT = hrdata_q;
	assign HREADYOUT_OUT = hready_q;
	assign HRESP_OUT = hresp_q;
	assign SDATA_IN_OUT = sdi_q;
	assign DAC_LEFT_OUT = dac_q[0];
	assign DAC_RIGHT_OUT = dac_q[1];
endmodule : actag_codec_link

// ---- rtl/actag_regs.svh ----
// register offsets, field positions, reset values and frame constants of the slot tag handler
`ifndef ACTAG_REGS_SVH
`define ACTAG_REGS_SVH
`define ACTAG_CTRL_OFS 8'h00
`define ACTAG_ADC_RATE_OFS 8'h04
`define ACTAG_DAC_RATE_OFS 8'h08
`define ACTAG_ADC_LEFT_OFS 8'h0c
`define ACTAG_ADC_RIGHT_OFS 8'h10
`define ACTAG_DAC_LEFT_OFS 8'h14
`define ACTAG_DAC_RIGHT_OFS 8'h18
`define ACTAG_STATUS_OFS 8'h1c
`define ACTAG_CTRL_RUN_BIT 0
`define ACTAG_CTRL_RDE_BIT 1
`define ACTAG_CTRL_ZERO_BIT 2
`define ACTAG_CTRL_RST 3'h0
`define ACTAG_RATE_RST 16'hbb80
`define ACTAG_BASE_RATE 48000
`define ACTAG_TAG_READY_BIT 15
`define ACTAG_TAG_SLOT1_BIT 14
`define ACTAG_TAG_SLOT2_BIT 13
`define ACTAG_TAG_LEFT_BIT 12
`define ACTAG_TAG_RIGHT_BIT 11
`define ACTAG_STAT_ADDR_BASE 16'h7400
`define ACTAG_STAT_ADDR_LREQ_BIT 7
`define ACTAG_STAT_ADDR_RREQ_BIT 6
`define ACTAG_STAT_DATA_BASE 16'hf800
`define ACTAG_STAT_DATA_LREQ_BIT 8
`define ACTAG_STAT_DATA_RREQ_BIT 0
`define ACTAG_TAG_LAST_BIT 5'd15
`define ACTAG_SLOT_LAST_BIT 5'd19
`define ACTAG_LAST_SLOT 4'd12
`endif

// ---- rtl/actag_pkg.sv ----
// types shared by the slot tag handler files
package actag_pkg;
	typedef logic [15:0] actag_sample_t;
	typedef struct packed {
		logic starve_zero;
		logic req_disp_en;
		logic run;
	} actag_ctrl_t;
	typedef struct packed {
		actag_sample_t tag;
		actag_sample_t left;
		actag_sample_t right;
	} actag_rx_frame_t;
	typedef enum logic {
		LNK_IDLE,
		LNK_FRAME
	} actag_link_state_t;
endpackage : actag_pkg

// ---- rtl/actag_rate_gen.sv ----
// per-frame sample tick generator from a rate in hertz against the frame rate
module actag_rate_gen #(
	parameter int RATE_W = 16,
	parameter int BASE = 48000
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic step_in,
	input wire logic [RATE_W-1:0] rate_in,
	output logic tick_out
);
	localparam logic [RATE_W:0] BASE_W = (RATE_W+1)'(BASE);

	if (BASE >= (64'd1 << RATE_W)) begin : g_bad_width
		$error("rate width too narrow for the frame rate");
	end

	logic [RATE_W-1:0] acc_q;
	logic [RATE_W-1:0] acc_d;
	logic tick_q;
	logic [RATE_W:0] rate_eff;
	logic [RATE_W:0] sum;
	logic hit;

	// clamp so the accumulator stays below the base and can never run away
	assign rate_eff = ({1'b0, rate_in} > BASE_W) ? BASE_W : {1'b0, rate_in};
	assign sum = {1'b0, acc_q} + rate_eff;
	// whole divisors of the base give even spacing, others mix two spacings with the remainder carried so the average rate stays exact
	assign hit = sum >= BASE_W;
	assign acc_d = hit ? RATE_W'(sum - BASE_W) : RATE_W'(sum);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acc_q <= '0;
			tick_q <= 1'b0;
		end else if (step_in) begin
			acc_q <= acc_d;
			tick_q <= hit;
		end
	end

	assign tick_out = tick_q;
endmodule : actag_rate_gen

// ---- test/actag_codec_link_asserts.sv ----
// port-level checks for the codec end of the serial audio link
module actag_codec_link_asserts (
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire logic HSEL_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic HREADY_IN,
	input wire logic [31:0] HRDATA_OUT,
	input wire logic HREADYOUT_OUT,
	input wire logic HRESP_OUT,
	input wire logic BIT_CLK_IN,
	input wire logic SYNC_IN,
	input wire logic SDATA_IN_OUT,
	input wire actag_pkg::actag_sample_t DAC_LEFT_OUT,
	input wire actag_pkg::actag_sample_t DAC_RIGHT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import actag_pkg::*;
	logic bclk_q, sync_q;
	logic [8:0] bit_cnt_q;
	logic [39:0] shift_q;
	actag_sample_t tag_q;
	wire taken = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	wire bclk_fall = bclk_q & ~BIT_CLK_IN;
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	// bits captured where the host samples them, at the bit clock fall
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			bclk_q <= 1'b0;
			sync_q <= 1'b0;
			bit_cnt_q <= 9'h1ff;
			shift_q <= '0;
			tag_q <= '0;
		end else begin
			bclk_q <= BIT_CLK_IN;
			sync_q <= SYNC_IN;
			if (SYNC_IN && !sync_q) begin
				bit_cnt_q <= 9'h000;
			end else if (bclk_fall && bit_cnt_q != 9'h1ff) begin
				bit_cnt_q <= bit_cnt_q + 9'h001;
			end
			if (bclk_fall) begin
				shift_q <= {shift_q[38:0], SDATA_IN_OUT};
			end
			if (bit_cnt_q == 9'h010) begin
				tag_q <= shift_q[15:0];
			end
		end
	end
	sequence s_wait_then_ready;
		!HREADYOUT_OUT ##1 HREADYOUT_OUT;
	endsequence
	property p_read_wait;
		taken && !HWRITE_IN |=> s_wait_then_ready;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer not after one wait cycle");
	property p_write_nowait;
		taken && HWRITE_IN |=> HREADYOUT_OUT;
	endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write data phase stretched");
	property p_resp_okay;
		HRESP_OUT == 1'b0;
	endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
	property p_rdata_hold;
		!$rose(HREADYOUT_OUT) |-> $stable(HRDATA_OUT);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside a read completion");
	property p_dac_at_frame;
		$changed(DAC_LEFT_OUT) || $changed(DAC_RIGHT_OUT) |-> SYNC_IN;
	endproperty
	a_dac_at_frame: assert property (p_dac_at_frame) else $error("dac output changed away from frame start");
	property p_tag_fields;
		bit_cnt_q == 9'h011 |-> tag_q[14] == tag_q[13] && tag_q[10:0] == 11'h000;
	endproperty
	a_tag_fields: assert property (p_tag_fields) else $error("status slot flags disagree in tag");
	property p_status_pair;
		bit_cnt_q == 9'h038 && tag_q[14] |-> shift_q[39:24] == {8'h74, ~shift_q[12], ~shift_q[4], 6'h00}
			&& shift_q[19:13] == 7'h7c && shift_q[11:5] == 7'h00 && shift_q[3:0] == 4'h0;
	endproperty
	a_status_pair: assert property (p_status_pair) else $error("request bits not mirrored across slots");
	property p_status_off;
		bit_cnt_q == 9'h038 && !tag_q[14] |-> shift_q == 40'h0;
	endproperty
	a_status_off: assert property (p_status_off) else $error("status slots not empty while display off");
	property p_adc_zero;
		(bit_cnt_q == 9'h04c && !tag_q[12]) || (bit_cnt_q == 9'h060 && !tag_q[11]) |-> shift_q[19:0] == 20'h0;
	endproperty
	a_adc_zero: assert property (p_adc_zero) else $error("unflagged adc slot not zero");
endmodule : actag_codec_link_asserts

// ---- test/actag_host_model.sv ----
// behavioural host serial port: bit clock, frame sync and both slot streams
module actag_host_model (
	output logic bit_clk_out,
	output logic sync_out,
	output logic sdata_out,
	input wire logic sdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import actag_pkg::*;
	int policy = 0;
	actag_rx_frame_t rx, held;
	actag_rx_frame_t q[$];
	actag_sample_t slot1, slot2;
	logic have;
	initial begin
		bit_clk_out = 1'b0;
		sync_out = 1'b0;
		sdata_out = 1'b0;
	end
	task automatic clear();
		q.delete();
		have = 1'b0;
		rx = '0;
		slot1 = 16'h74c0;
	endtask : clear
	task automatic frame();
		logic [255:0] tx, rxv;
		actag_sample_t tag;
		logic rl, rr;
		rl = ~slot1[7];
		rr = ~slot1[6];
		// whole tag settled before the first bit leaves
		if (policy == 0) begin
			tag = rx.tag & 16'h9800;
			held = rx;
		end else if (policy == 1) begin
			if (rx.tag[12]) q.push_back(rx);
			if ((rl | rr) && q.size() > 0) begin
				held = q.pop_front();
				have = 1'b1;
			end
			tag = {3'b100, rl & have, rr & have, 11'h000};
		end else begin
			tag = 16'h8000;
		end
		tx = {tag, 40'h0, tag[12] ? held.left : 16'h0000, 4'h0, tag[11] ? held.right : 16'h0000, 164'h0};
		#7; // keeps link edges off the core clock edges
		for (int i = 255; i >= 0; i--) begin
			bit_clk_out = 1'b1;
			sync_out = (i > 239);
			sdata_out = tx[i];
			#100;
			bit_clk_out = 1'b0;
			rxv[i] = sdata_in;
			#100;
		end
		sdata_out = ~tx[0];
		rx = {rxv[255:240], rxv[199:184], rxv[179:164]};
		slot1 = rxv[239:224];
		slot2 = rxv[219:204];
		#303; // bit clock stands still between frames
	endtask : frame
endmodule : actag_host_model

// ---- test/actag_codec_link_tb.sv ----
// self-checking bench for the codec end of the serial audio link
`include "actag_regs.svh"
module actag_codec_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import actag_pkg::*;
	logic clk, nrst, hsel, hwrite, hready, hresp, sdi, bclk, sync, sdo;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	actag_sample_t dac_l, dac_r;
	int errors = 0;
	int cmp_count = 0;
	actag_codec_link dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .BIT_CLK_IN(bclk), .SYNC_IN(sync), .SDATA_OUT_IN(sdo),
		.SDATA_IN_OUT(sdi), .DAC_LEFT_OUT(dac_l), .DAC_RIGHT_OUT(dac_r));
	actag_host_model host (.bit_clk_out(bclk), .sync_out(sync), .sdata_out(sdo), .sdata_in(sdi));
	task automatic stop_test();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_word(input actag_sample_t got, input actag_sample_t exp);
		chk_reg({16'h0000, got}, {16'h0000, exp});
	endtask : chk_word
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		// realign to the core clock, a frame may have just ended off an edge
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask : rdchk
	task automatic pace(input int rate, input int per, input logic [2:0] ctl, input int pol, input actag_sample_t l,
		input actag_sample_t r);
		int last, nv, nr;
		actag_sample_t s1;
		host.policy = pol;
		bus(1'b1, `ACTAG_CTRL_OFS, 32'h0);
		bus(1'b1, `ACTAG_ADC_RATE_OFS, 32'(rate));
		bus(1'b1, `ACTAG_DAC_RATE_OFS, 32'(rate));
		bus(1'b1, `ACTAG_ADC_LEFT_OFS, {16'h0000, l});
		bus(1'b1, `ACTAG_ADC_RIGHT_OFS, {16'h0000, r});
		bus(1'b1, `ACTAG_CTRL_OFS, {29'h0, ctl});
		last = -1;
		nv = 0;
		nr = 0;
		for (int f = 0; f <= 2 * per; f++) begin
			host.frame();
			s1 = host.slot1;
			if (host.rx.tag[12]) begin
				if (last >= 0) chk_word(16'(f - last), 16'(per));
				last = f;
				nv++;
			end
			chk_word(host.rx.left, host.rx.tag[12] ? l : 16'h0000);
			chk_word(host.rx.right, host.rx.tag[11] ? r : 16'h0000);
			nr += int'(~s1[7] & ctl[1]);
			chk_word(host.slot2, ctl[1] ? (16'hf800 | {7'h0, ~s1[7], 7'h0, ~s1[6]}) : 16'h0000);
			if (!ctl[1]) chk_word(s1, 16'h0000);
		end
		chk_reg(32'(nv > 1), 32'h1);
		if (ctl[1]) chk_word(16'(nr), 16'(nv));
		chk_word(dac_l, l);
		chk_word(dac_r, r);
	endtask : pace
	task automatic starve(input logic [2:0] ctl, input actag_sample_t exp);
		bus(1'b1, `ACTAG_CTRL_OFS, {29'h0, ctl});
		repeat (7) host.frame();
		chk_word(dac_l, exp);
	endtask : starve
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// whole run is about 43 frames of 2060 core cycles
	initial begin
		#2_400_000;
		errors++;
		stop_test();
	end
	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		host.clear();
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk_word(dac_l, 16'h0000);
		rdchk(`ACTAG_CTRL_OFS, 32'h0);
		rdchk(`ACTAG_ADC_RATE_OFS, {16'h0000, `ACTAG_RATE_RST});
		rdchk(`ACTAG_DAC_RATE_OFS, {16'h0000, `ACTAG_RATE_RST});
		bus(1'b1, `ACTAG_DAC_LEFT_OFS, 32'h0000ffff);
		rdchk(`ACTAG_DAC_LEFT_OFS, 32'h0);
		rdchk(8'h20, 32'h0);
		pace(8000, 6, 3'h3, 1, 16'h1234, 16'habcd);
		pace(12000, 4, 3'h1, 0, 16'h5a5a, 16'h0f0f);
		pace(16000, 3, 3'h3, 1, 16'h2222, 16'h3333);
		host.policy = 2;
		starve(3'h3, 16'h2222);
		starve(3'h7, 16'h0000);
		stop_test();
	end
endmodule : actag_codec_link_tb
bind actag_codec_link actag_codec_link_asserts u_chk (.CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN),
	.HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
	.HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .BIT_CLK_IN(BIT_CLK_IN),
	.SYNC_IN(SYNC_IN), .SDATA_IN_OUT(SDATA_IN_OUT), .DAC_LEFT_OUT(DAC_LEFT_OUT), .DAC_RIGHT_OUT(DAC_RIGHT_OUT));
